// ==== core/ldp_ctrl.sv ====
// diagnostic, power-save, thermal and staggered sink control for a 16-channel driver
//
// Contract
// - hidden mode: check current from first pwm clock to chosen count
// - open and short results latched when check current stops
// - grayscale on/off keeps running during the check current
// - without hidden mode outputs follow grayscale only
// - hidden mode has no effect in power save; code still keeps leak detect off while hidden mode is set
// - every fault flag reads 1 for fault, 0 for normal
// - power save enabled while select bits are nonzero; code enters it only with select 01 or 10
// - select 01 or 10 plus all-zero grayscale write enters power save
// - shift clock rise with select 01 leaves power save
// - after leaving, outputs wait for next period's first pwm clock; code releases them at once when select is cleared
// - reference short sets its flag and forces outputs off
// - warning flag set while hot, outputs untouched
// - warning cleared at grayscale strobe when below threshold
// - shutdown forces all outputs off and sets thermal error together
// - outputs stay off until cool and next period's first pwm clock
// - thermal error holds until grayscale strobe below shutdown level
// - groups: 0/7/8/15, 1/6/9/14, 2/5/10/13, 3/4/11/12
// - groups switch in sequence with a small delay between them
// - leak detection off while hidden mode is on
// - without hidden mode, open and short flags of off outputs read 0
`timescale 1ns/10ps
`default_nettype none
`include "ldp_params.svh"
module ldp_ctrl
  import ldp_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic PWM_COUNT_CLOCK,
  input wire logic TRANSFER_STROBE,
  input wire logic SHIFT_CLOCK,
  input wire logic GS_WRITE_SEL,
  input wire logic GS_ALL_ZERO,
  input wire logic PERIOD_FIRST,
  input wire logic [15:0] PWM_ON,
  input wire logic [15:0] OPEN_CMP,
  input wire logic [15:0] SHORT_CMP,
  input wire logic [15:0] LEAK_CMP,
  input wire logic TEMP_WARN,
  input wire logic TEMP_SHUT,
  input wire logic TEMP_COOL,
  input wire logic REF_SHORT,
  output logic [15:0] SINK_OUTPUT,
  output logic HIDDEN_CHECK_CURRENT,
  output logic LEAK_DETECT_EN,
  output logic POWER_SAVE_MODE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  ldp_state_s q;
  ldp_state_s d;
  logic gs_rise;
  logic st_rise;
  logic sc_rise;
  logic first_clk;
  logic gs_wr;
  logic [7:0] cnt_n;
  logic [7:0] target;
  logic samp;
  logic force_off;
  logic [15:0] staged;

  // group of a channel: mirrored pairs inside each half
  function automatic logic [1:0] grp(input int ch);
    logic [2:0] c;
    c = 3'(ch % 8);
    grp = (c < 3'h4) ? c[1:0] : 2'(3'h7 - c);
  endfunction

  // register address decode, shared by read and write
  function automatic logic reg_ok(input logic [7:0] a);
    reg_ok = (a == `LDP_OFS_CTRL) || (a == `LDP_OFS_STAT) ||
             (a == `LDP_OFS_OPEN) || (a == `LDP_OFS_SHORT) ||
             (a == `LDP_OFS_LEAK);
  endfunction

  // pin edges from synced samples
  assign gs_rise = q.pin_s[0] & ~q.pin_p[0];
  assign st_rise = q.pin_s[1] & ~q.pin_p[1];
  assign sc_rise = q.pin_s[2] & ~q.pin_p[2];
  assign first_clk = gs_rise & PERIOD_FIRST;
  assign gs_wr = st_rise & GS_WRITE_SEL;
  // outputs forced off by shutdown latch, live shutdown or reference short
  assign force_off = q.thermal_shutdown | q.ana_g[1] | q.ana_g[3];

  // sample count picked by the check sample time field
  always_comb
  begin
    case (q.samp_sel)
      2'h0: target = `LDP_SAMP_CNT0;
      2'h1: target = `LDP_SAMP_CNT1;
      2'h2: target = `LDP_SAMP_CNT2;
      default: target = `LDP_SAMP_CNT3;
    endcase
  end

  // pwm clocks since the period's first one, saturating
  always_comb
  begin
    if (first_clk)
      cnt_n = 8'h01;
    else if (gs_rise && q.cnt != 8'hFF)
      cnt_n = q.cnt + 8'h01;
    else
      cnt_n = q.cnt;
  end
  assign samp = gs_rise & (cnt_n == target) & (q.cnt != 8'h00);

  // per-channel pick of the stage matching its group
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_grp
      localparam logic [1:0] G = grp(gi);
      assign staged[gi] = (G == 2'h0) ? q.raw[gi] :
                          (G == 2'h1) ? q.stg1[gi] :
                          (G == 2'h2) ? q.stg2[gi] : q.stg3[gi];
    end
  endgenerate

  // next state of the whole block
  always_comb
  begin
    d = q;
    // two-flop synchronisers, then one stage kept for edge finding
    d.pin_m = {SHIFT_CLOCK, TRANSFER_STROBE, PWM_COUNT_CLOCK};
    d.pin_s = q.pin_m;
    d.pin_p = q.pin_s;
    d.ana_m = {REF_SHORT, TEMP_COOL, TEMP_SHUT, TEMP_WARN};
    d.ana_s = q.ana_m;
    d.cmp_m = {LEAK_CMP, SHORT_CMP, OPEN_CMP};
    d.cmp_s = q.cmp_m;
    // thermal and reference levels taken at pwm clock edges
    if (gs_rise)
      d.ana_g = q.ana_s;
    d.cnt = cnt_n;

    // hidden check current window
    if (first_clk && q.hid_mode && !q.power_save_mode)
      d.hid_on = 1'b1;
    else if (samp || q.power_save_mode)
      d.hid_on = 1'b0;

    // fault capture at the sample instant
    if (samp)
    begin
      if (q.hid_on)
      begin
        d.open_f = q.cmp_s[15:0];
        d.short_f = q.cmp_s[31:16];
      end
      else
      begin
        d.open_f = q.cmp_s[15:0] & PWM_ON;
        d.short_f = q.cmp_s[31:16] & PWM_ON;
      end
    end
    // leak result at end of display period, only for off outputs
    if (first_clk)
      d.leak_f = (q.leak_en && !q.hid_mode) ?
                 (q.cmp_s[47:32] & ~PWM_ON) : 16'h0000;

    // warning: set while hot, cleared at grayscale strobe when cool
    if (q.ana_g[0])
      d.warn = 1'b1;
    else if (gs_wr)
      d.warn = 1'b0;
    // thermal error flag and shutdown latch
    if (q.ana_g[1])
      d.thermal_error_flag = 1'b1;
    else if (gs_wr)
      d.thermal_error_flag = 1'b0;
    if (q.ana_g[1])
      d.thermal_shutdown = 1'b1;
    else if (first_clk && q.ana_g[2])
      d.thermal_shutdown = 1'b0;

    // power save entry and exit
    if (q.power_save_mode && sc_rise && q.ps_sel == 2'h1)
    begin
      d.power_save_mode = 1'b0;
      d.ps_hold = 1'b1;
    end
    else if (!q.power_save_mode && gs_wr && GS_ALL_ZERO &&
             (q.ps_sel == 2'h1 || q.ps_sel == 2'h2))
      d.power_save_mode = 1'b1;
    else if (q.ps_sel == 2'h0)
      d.power_save_mode = 1'b0;
    if (first_clk)
      d.ps_hold = 1'b0;

    // grayscale on/off passes unchanged unless held off
    d.raw = (q.power_save_mode || q.ps_hold) ? 16'h0000 : PWM_ON;
    // group stages move one step per delay tick
    if (q.dly == 3'(`LDP_STAGGER_CYC - 1))
    begin
      d.dly = 3'h0;
      d.stg1 = q.raw;
      d.stg2 = q.stg1;
      d.stg3 = q.stg2;
    end
    else
      d.dly = q.dly + 3'h1;
    d.sink = force_off ? 16'h0000 : staged;

    // axi write: address and data taken in either order
    if (S_AXI_AWVALID && q.awready)
    begin
      d.awready = 1'b0;
      d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready)
    begin
      d.wready = 1'b0;
      d.wdata = S_AXI_WDATA;
      d.wstrb0 = S_AXI_WSTRB[0];
    end
    if (!q.awready && !q.wready && !q.bvalid)
    begin
      d.bvalid = 1'b1;
      d.bresp = reg_ok(q.awaddr) ? 2'h0 : 2'h2;
      if (q.awaddr == `LDP_OFS_CTRL && q.wstrb0)
      begin
        d.hid_mode = q.wdata[`LDP_CTRL_HID];
        d.samp_sel = q.wdata[`LDP_CTRL_SAMP +: 2];
        d.ps_sel = q.wdata[`LDP_CTRL_PSS +: 2];
        d.leak_en = q.wdata[`LDP_CTRL_LEAK];
      end
    end
    if (q.bvalid && S_AXI_BREADY)
    begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // axi read: one beat answered the cycle after the address
    if (S_AXI_ARVALID && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = reg_ok(S_AXI_ARADDR) ? 2'h0 : 2'h2;
      case (S_AXI_ARADDR)
        `LDP_OFS_CTRL: d.rdata = {26'h0, q.leak_en, q.ps_sel,
                                  q.samp_sel, q.hid_mode};
        `LDP_OFS_STAT: d.rdata = {27'h0, q.hid_on, q.power_save_mode, q.thermal_error_flag,
                                  q.warn, q.ana_g[3]};
        `LDP_OFS_OPEN: d.rdata = {16'h0, q.open_f};
        `LDP_OFS_SHORT: d.rdata = {16'h0, q.short_f};
        `LDP_OFS_LEAK: d.rdata = {16'h0, q.leak_f};
        default: d.rdata = 32'h0;
      endcase
    end
    if (q.rvalid && S_AXI_RREADY)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // gated levels built from next state, so each port leaves a flop in step
    d.hid_out = d.hid_on & ~(d.thermal_shutdown | d.ana_g[1] | d.ana_g[3]);
    d.leak_out = d.leak_en & ~d.hid_mode;
  end

  // state register with synchronous reset
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end
    else
      q <= d;
  end

  // outputs straight from state flops
  assign SINK_OUTPUT = q.sink;
  assign HIDDEN_CHECK_CURRENT = q.hid_out;
  assign LEAK_DETECT_EN = q.leak_out;
  assign POWER_SAVE_MODE = q.power_save_mode;
  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY = q.wready;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign S_AXI_RVALID = q.rvalid;

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  sequence s_hid_start;
    first_clk && q.hid_mode && !q.power_save_mode;
  endsequence
  // all-zero grayscale write while power save is armed but not yet on
  sequence s_zero_write;
    gs_wr && GS_ALL_ZERO && !q.power_save_mode && (q.ps_sel == 2'h1 || q.ps_sel == 2'h2);
  endsequence

  a_hid_start: assert property (s_hid_start |=> q.hid_on)
    else $error("check current did not start");
  a_hid_stop: assert property (samp |=> !q.hid_on)
    else $error("check current did not stop at sample count");
  a_flag_cap: assert property (samp && q.hid_on |=>
    q.open_f == $past(q.cmp_s[15:0]))
    else $error("open flags not captured at check end");
  a_off_zero: assert property (samp && !q.hid_on |=>
    (q.short_f & ~$past(PWM_ON)) == 16'h0000)
    else $error("short flag of off output set");
  a_open_off: assert property (samp && !q.hid_on |=>
    (q.open_f & ~$past(PWM_ON)) == 16'h0000)
    else $error("open flag of off output set");
  a_psm_block: assert property (q.power_save_mode |=> !q.hid_on)
    else $error("check current active in power save");
  a_psm_exit: assert property (q.power_save_mode && sc_rise && q.ps_sel == 2'h1
    |=> !q.power_save_mode && q.ps_hold)
    else $error("power save not left on shift clock");
  a_hold_dark: assert property (q.ps_hold |=> q.raw == 16'h0000)
    else $error("outputs on before next period");
  a_shut_off: assert property (q.ana_g[1] |=>
    q.thermal_error_flag && q.sink == 16'h0000)
    else $error("shutdown did not force off with flag");
  a_ref_off: assert property (q.ana_g[3] |=> q.sink == 16'h0000)
    else $error("reference short did not force off");
  a_tef_hold: assert property (q.thermal_error_flag && !gs_wr |=> q.thermal_error_flag)
    else $error("thermal error cleared without strobe");
  a_warn_clr: assert property (gs_wr && !q.ana_g[0] |=> !q.warn)
    else $error("warning not cleared at strobe");
  a_grp_order: assert property (q.dly == 3'(`LDP_STAGGER_CYC - 1)
    |=> q.stg1 == $past(q.raw, 1) && q.stg2 == $past(q.stg1, 1) &&
    q.stg3 == $past(q.stg2, 1))
    else $error("group stages out of order");
  a_leak_off: assert property (q.hid_mode |-> !LEAK_DETECT_EN)
    else $error("leak detect on in hidden mode");
  a_psm_enter: assert property (s_zero_write |=> q.power_save_mode)
    else $error("power save not entered on zero write");
  a_psm_off: assert property (q.ps_sel == 2'h0 |=> !q.power_save_mode)
    else $error("power save on with select cleared");
  a_warn_set: assert property (q.ana_g[0] |=> q.warn)
    else $error("warning not set while hot");
  a_tsd_keep: assert property (q.thermal_shutdown && !first_clk |=>
    q.thermal_shutdown && q.sink == 16'h0000)
    else $error("outputs released before next period");
  a_hid_gate: assert property (HIDDEN_CHECK_CURRENT |-> q.hid_on && !force_off)
    else $error("check current on while forced off");
  a_hid_born: assert property ($rose(q.hid_on) |->
    $past(first_clk && q.hid_mode && !q.power_save_mode))
    else $error("check current started outside a first pwm clock");

endmodule
`default_nettype wire

// ==== core/ldp_params.svh ====
// constants of the led diagnostic and protection control block
`ifndef LDP_PARAMS_SVH
`define LDP_PARAMS_SVH
// register byte offsets
`define LDP_OFS_CTRL 8'h00
`define LDP_OFS_STAT 8'h04
`define LDP_OFS_OPEN 8'h08
`define LDP_OFS_SHORT 8'h0C
`define LDP_OFS_LEAK 8'h10
// control field positions
`define LDP_CTRL_HID 0
`define LDP_CTRL_SAMP 1
`define LDP_CTRL_PSS 3
`define LDP_CTRL_LEAK 5
`define LDP_CTRL_RST 8'h00
// status field positions
`define LDP_ST_REF 0
`define LDP_ST_WARN 1
`define LDP_ST_TEF 2
`define LDP_ST_PSM 3
`define LDP_ST_HID 4
// pwm clock counts chosen by the check sample time field
`define LDP_SAMP_CNT0 8'h11
`define LDP_SAMP_CNT1 8'h21
`define LDP_SAMP_CNT2 8'h41
`define LDP_SAMP_CNT3 8'h81
// delay between output groups
`define LDP_CLK_NS 5
`define LDP_STAGGER_NS 20
`define LDP_STAGGER_CYC ((`LDP_STAGGER_NS + `LDP_CLK_NS - 1) / `LDP_CLK_NS)
`endif

// ==== core/ldp_pkg.sv ====
// types of the led diagnostic and protection control block
package ldp_pkg;
  typedef struct packed {
    logic [2:0] pin_m;
    logic [2:0] pin_s;
    logic [2:0] pin_p;
    logic [3:0] ana_m;
    logic [3:0] ana_s;
    logic [3:0] ana_g;
    logic [47:0] cmp_m;
    logic [47:0] cmp_s;
    logic hid_mode;
    logic [1:0] samp_sel;
    logic [1:0] ps_sel;
    logic leak_en;
    logic [7:0] cnt;
    logic hid_on;
    logic power_save_mode;
    logic ps_hold;
    logic thermal_shutdown;
    logic warn;
    logic thermal_error_flag;
    logic hid_out;
    logic leak_out;
    logic [15:0] open_f;
    logic [15:0] short_f;
    logic [15:0] leak_f;
    logic [2:0] dly;
    logic [15:0] stg1;
    logic [15:0] stg2;
    logic [15:0] stg3;
    logic [15:0] raw;
    logic [15:0] sink;
    logic awready;
    logic wready;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ldp_state_s;
endpackage

// ==== bench/ldp_disp_ctl.sv ====
// display controller model: pwm count clock, transfer strobe and shift clock
`timescale 1ns/10ps
`default_nettype none
module ldp_disp_ctl #(parameter int PERIOD = 64)
(
  input wire logic mclk,
  input wire logic run,
  output logic pwm_clk,
  output logic strobe,
  output logic shift_clk,
  output logic gs_sel,
  output logic gs_zero,
  output logic first
);
  int n = 0;
  // 8 MHz pwm clock, phase unrelated to mclk, stands low while idle
  initial
  begin
    pwm_clk = 1'b0;
    strobe = 1'b0;
    shift_clk = 1'b0;
    gs_sel = 1'b0;
    gs_zero = 1'b0;
    #1.3;
    forever
    begin
      #62.5;
      pwm_clk = run ? ~pwm_clk : 1'b0;
    end
  end
  // display period position, counted on the falling edge away from sampling
  always @(negedge pwm_clk) n <= (n == PERIOD - 1) ? 0 : n + 1;
  always @(posedge mclk) first <= (n == 0);
  // strobe pulse with its write qualifiers held across it
  task automatic pulse_strobe(input logic sel, input logic zero);
    @(posedge mclk);
    gs_sel <= sel;
    gs_zero <= zero;
    strobe <= 1'b1;
    repeat (8) @(posedge mclk);
    strobe <= 1'b0;
    repeat (8) @(posedge mclk);
    gs_sel <= 1'b0;
    gs_zero <= 1'b0;
  endtask
  // one shift clock pulse
  task automatic pulse_shift();
    @(posedge mclk);
    shift_clk <= 1'b1;
    repeat (8) @(posedge mclk);
    shift_clk <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== bench/ldp_tb.sv ====
// self-checking bench for the led diagnostic and protection control
`timescale 1ns/10ps
`default_nettype none
`include "ldp_params.svh"
module testbench;
  logic MCLK, RESET_N, run, pclk, lat, sclk, gsel, gzero, first;
  logic [15:0] pwm_on, open_c, short_c, leak_c, sink;
  logic warn, shut, cool, refs, hcur, leak_en, power_save_mode;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [7:0] regs [5];
  int failures, checks, cycles, h;
  ldp_disp_ctl ctl (.mclk(MCLK), .run(run), .pwm_clk(pclk), .strobe(lat), .shift_clk(sclk),
    .gs_sel(gsel), .gs_zero(gzero), .first(first));
  ldp_ctrl dut (.MCLK(MCLK), .RESET_N(RESET_N), .PWM_COUNT_CLOCK(pclk), .TRANSFER_STROBE(lat),
    .SHIFT_CLOCK(sclk), .GS_WRITE_SEL(gsel), .GS_ALL_ZERO(gzero), .PERIOD_FIRST(first),
    .PWM_ON(pwm_on), .OPEN_CMP(open_c), .SHORT_CMP(short_c), .LEAK_CMP(leak_c),
    .TEMP_WARN(warn), .TEMP_SHUT(shut), .TEMP_COOL(cool), .REF_SHORT(refs),
    .SINK_OUTPUT(sink), .HIDDEN_CHECK_CURRENT(hcur), .LEAK_DETECT_EN(leak_en),
    .POWER_SAVE_MODE(power_save_mode), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // 200 MHz clock and a cycle ceiling against hangs
  always #2.5 MCLK = ~MCLK;
  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask
  // count cycles with the check current on
  task automatic hid_cycles(input int k, output int n);
    n = 0;
    repeat (k)
    begin
      @(posedge MCLK);
      if (hcur === 1'b1) n++;
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge MCLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge MCLK);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 50);
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, r});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge MCLK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge MCLK);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 50);
    chk(rdata, d);
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, r});
    rready <= 1'b0;
  endtask
  initial
  begin
    MCLK = 1'b0;
    RESET_N = 1'b0;
    run = 1'b0;
    {pwm_on, open_c, short_c, leak_c} = '0;
    {warn, shut, refs} = '0;
    cool = 1'b1;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    failures = 0;
    checks = 0;
    cycles = 0;
    regs = '{`LDP_OFS_CTRL, `LDP_OFS_STAT, `LDP_OFS_OPEN, `LDP_OFS_SHORT, `LDP_OFS_LEAK};
    cyc(6);
    RESET_N <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0, 2'h0);
    rd(8'h14, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    wr(`LDP_OFS_CTRL, 32'h20, 2'h0);
    chk(leak_en, 1'b1);
    // hidden check with half the channels lit by grayscale
    pwm_on <= 16'h00FF;
    open_c <= 16'hA5C3;
    short_c <= 16'h0F0F;
    leak_c <= 16'h3C3C;
    wr(`LDP_OFS_CTRL, 32'h21, 2'h0);
    chk(leak_en, 1'b0);
    run <= 1'b1;
    hid_cycles(1000, h);
    chk(32'(h >= 399 && h <= 401), 32'h1);
    chk(sink, 16'h00FF);
    rd(`LDP_OFS_OPEN, 32'hA5C3, 2'h0);
    rd(`LDP_OFS_SHORT, 32'h0F0F, 2'h0);
    rd(`LDP_OFS_LEAK, 32'h0, 2'h0);
    wr(`LDP_OFS_CTRL, 32'h20, 2'h0);
    hid_cycles(1700, h);
    chk(h, 0);
    rd(`LDP_OFS_OPEN, 32'h00C3, 2'h0);
    rd(`LDP_OFS_SHORT, 32'h000F, 2'h0);
    rd(`LDP_OFS_LEAK, 32'h3C00, 2'h0);
    // warning, shutdown and recovery
    pwm_on <= 16'hFFFF;
    warn <= 1'b1;
    cyc(100);
    chk(sink, 16'hFFFF);
    rd(`LDP_OFS_STAT, 32'h2, 2'h0);
    shut <= 1'b1;
    cool <= 1'b0;
    cyc(100);
    chk(sink, 16'h0);
    rd(`LDP_OFS_STAT, 32'h6, 2'h0);
    {shut, warn} <= 2'b00;
    cool <= 1'b1;
    cyc(100);
    rd(`LDP_OFS_STAT, 32'h6, 2'h0);
    ctl.pulse_strobe(1'b1, 1'b0);
    cyc(20);
    rd(`LDP_OFS_STAT, 32'h0, 2'h0);
    cyc(1700);
    chk(sink, 16'hFFFF);
    // staggered groups, off then on
    pwm_on <= 16'h0;
    cyc(4);
    chk(sink & 16'h9999, 16'h1818);
    cyc(20);
    chk(sink, 16'h0);
    pwm_on <= 16'hFFFF;
    cyc(4);
    chk(sink & 16'h9999, 16'h8181);
    cyc(20);
    chk(sink, 16'hFFFF);
    // power save entry, hidden mode ignored, exit
    pwm_on <= 16'h0;
    wr(`LDP_OFS_CTRL, 32'h08, 2'h0);
    ctl.pulse_strobe(1'b1, 1'b1);
    cyc(10);
    chk(power_save_mode, 1'b1);
    rd(`LDP_OFS_STAT, 32'h8, 2'h0);
    wr(`LDP_OFS_CTRL, 32'h09, 2'h0);
    hid_cycles(1700, h);
    chk(h, 0);
    wr(`LDP_OFS_CTRL, 32'h08, 2'h0);
    pwm_on <= 16'hFFFF;
    ctl.pulse_shift();
    cyc(10);
    chk(power_save_mode, 1'b0);
    cyc(1700);
    chk(sink, 16'hFFFF);
    // reference pin short
    refs <= 1'b1;
    cyc(100);
    chk(sink, 16'h0);
    rd(`LDP_OFS_STAT, 32'h1, 2'h0);
    close_out();
  end
endmodule
`default_nettype wire
